// *** include/sbg_pkg.sv ***
/*
 * constants shared by the serial bit-rate timer: register offsets,
 * control field positions, reset values, rate multipliers, bus states.
 * assumes a single 25 MHz system clock and a 32-bit avalon-mm slave port.
 */
package sbg_pkg;

    // ************************************************************
    // register byte offsets
    // ************************************************************
    localparam logic [3:0] OFS_CTRL    = 4'h0;
    localparam logic [3:0] OFS_DIV_LO  = 4'h4;
    localparam logic [3:0] OFS_DIV_HI  = 4'h8;
    localparam logic [3:0] OFS_STATUS  = 4'hC;

    // ************************************************************
    // baud_control_reg field positions
    // ************************************************************
    localparam int CTRL_WIDE = 0;
    localparam int CTRL_HS   = 1;
    localparam int CTRL_SYNC = 2;
    localparam int CTRL_EN   = 3;

    // ************************************************************
    // status field positions
    // ************************************************************
    localparam int STAT_RX_IDLE = 0;
    localparam int STAT_RUN     = 1;
    localparam int STAT_CNT_LSB = 16;

    // ************************************************************
    // reset values
    // ************************************************************
    localparam logic       CTRL_BIT_RST = 1'h0;
    localparam logic [7:0] DIV_RST      = 8'h00;
    localparam logic [15:0] CNT_RST     = 16'h0000;

    // ************************************************************
    // bit period multipliers, in timer periods per bit
    // ************************************************************
    localparam logic [6:0] MULT_ASYNC_8_LOW   = 7'h40;
    localparam logic [6:0] MULT_ASYNC_8_HIGH  = 7'h10;
    localparam logic [6:0] MULT_ASYNC_16_LOW  = 7'h10;
    localparam logic [6:0] MULT_ASYNC_16_HIGH = 7'h04;
    localparam logic [6:0] MULT_SYNC          = 7'h04;

    // ************************************************************
    // bus slave states
    // ************************************************************
    typedef enum logic [1:0] {
        SBG_BUS_IDLE = 2'b01,
        SBG_BUS_ACK  = 2'b10
    } sbg_bus_state_t;

endpackage

// *** logic/sbg_timer.sv ***
/*
 * free-running down-counting period timer of the bit-rate generator.
 * assumes period is already narrowed to the selected width by the caller
 * and that clear comes from logic on the same clock.
 */
`timescale 1ns/100ps
module sbg_timer (
    // clock and reset
    input  wire logic        clk_sys,
    input  wire logic        srst,
    // control
    input  wire logic        run,
    input  wire logic        clear,
    input  wire logic [15:0] period,
    // state
    output logic      [15:0] count,
    output logic             tick
);

    logic [15:0] next_count;
    logic        next_tick;

    // ************************************************************
    // count down, reload and pulse on reaching zero
    // ************************************************************
    always_comb begin
        next_count = count;
        next_tick  = 1'b0;
        if (clear || !run) begin
            // restart at once so a new rate needs no old overflow
            next_count = period;
        end else if (count == 16'h0000) begin
            next_count = period; // reload and keep going
            next_tick  = 1'b1;   // one cycle per completed period
        end else begin
            next_count = count - 16'h0001;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            count <= sbg_pkg::CNT_RST;
            tick  <= 1'b0;
        end else begin
            count <= next_count;
            tick  <= next_tick;
        end
    end

endmodule

// *** logic/sbg_top.sv ***
/*
 * bit-rate generator of the serial port with its avalon-mm register slave.
 * assumes the transmitter and receiver sit on clk_sys and consume
 * timer_tick / bit_tick; auto-baud inputs come from the same clock domain.
 */
`timescale 1ns/100ps
module sbg_top (
    // clock and reset
    input  wire logic        clk_sys,
    input  wire logic        srst,
    // avalon-mm slave
    input  wire logic [3:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    // serial port side
    input  wire logic        receive_idle_flag,
    input  wire logic        autobaud_load,
    input  wire logic [15:0] autobaud_value,
    // rate outputs
    output logic             timer_tick,
    output logic             bit_tick,
    output logic             sync_mode,
    output logic             wide_counter_select
);

    // ************************************************************
    // declarations
    // ************************************************************
    sbg_pkg::sbg_bus_state_t state;
    sbg_pkg::sbg_bus_state_t next_state;
    logic        high_speed_select;
    logic        port_enable;
    logic [7:0]  divisor_low_byte;
    logic [7:0]  divisor_high_byte;
    logic        next_wide;
    logic        next_hs;
    logic        next_sync;
    logic        next_en;
    logic [7:0]  next_div_lo;
    logic [7:0]  next_div_hi;
    logic [31:0] next_readdata;
    logic        wr_acc;
    logic        sw_div_wr;
    logic        clear;
    logic [15:0] period;
    logic [15:0] count;
    logic [6:0]  mult;
    logic [5:0]  pre;
    logic [5:0]  next_pre;
    logic        next_bit_tick;

    // ************************************************************
    // bus slave: one wait cycle, then the answer
    // ************************************************************
    always_comb begin
        next_state = state;
        case (state)
            sbg_pkg::SBG_BUS_IDLE: begin
                if (avs_read || avs_write) begin
                    next_state = sbg_pkg::SBG_BUS_ACK;
                end
            end
            sbg_pkg::SBG_BUS_ACK: begin
                next_state = sbg_pkg::SBG_BUS_IDLE;
            end
            default: begin
                next_state = sbg_pkg::SBG_BUS_IDLE;
            end
        endcase
    end

    assign avs_waitrequest = (avs_read || avs_write) && (state != sbg_pkg::SBG_BUS_ACK);
    assign wr_acc          = avs_write && (state == sbg_pkg::SBG_BUS_ACK) && avs_byteenable[0];

    // read data captured during the wait cycle, stable at the accept edge
    always_comb begin
        next_readdata = avs_readdata;
        if (avs_read && (state == sbg_pkg::SBG_BUS_IDLE)) begin
            next_readdata = 32'h0000_0000;
            if (avs_address == sbg_pkg::OFS_CTRL) begin
                next_readdata[sbg_pkg::CTRL_WIDE] = wide_counter_select;
                next_readdata[sbg_pkg::CTRL_HS]   = high_speed_select;
                next_readdata[sbg_pkg::CTRL_SYNC] = sync_mode;
                next_readdata[sbg_pkg::CTRL_EN]   = port_enable;
            end else if (avs_address == sbg_pkg::OFS_DIV_LO) begin
                next_readdata[7:0] = divisor_low_byte;
            end else if (avs_address == sbg_pkg::OFS_DIV_HI) begin
                next_readdata[7:0] = divisor_high_byte;
            end else if (avs_address == sbg_pkg::OFS_STATUS) begin
                // rx idle lets software pick a safe moment for clock changes
                next_readdata[sbg_pkg::STAT_RX_IDLE] = receive_idle_flag;
                next_readdata[sbg_pkg::STAT_RUN]     = port_enable;
                next_readdata[31:sbg_pkg::STAT_CNT_LSB] = count;
            end
        end
    end

    // ************************************************************
    // control and divisor registers
    // ************************************************************
    always_comb begin
        next_wide   = wide_counter_select;
        next_hs     = high_speed_select;
        next_sync   = sync_mode;
        next_en     = port_enable;
        next_div_lo = divisor_low_byte;
        next_div_hi = divisor_high_byte;
        sw_div_wr   = 1'b0;
        // auto-baud loads first, so a software write to a divisor byte in the same cycle wins for that byte
        if (autobaud_load) begin
            next_div_lo = autobaud_value[7:0];
            next_div_hi = autobaud_value[15:8];
        end
        if (wr_acc) begin
            if (avs_address == sbg_pkg::OFS_CTRL) begin
                next_wide = avs_writedata[sbg_pkg::CTRL_WIDE];
                next_hs   = avs_writedata[sbg_pkg::CTRL_HS];
                next_sync = avs_writedata[sbg_pkg::CTRL_SYNC];
                next_en   = avs_writedata[sbg_pkg::CTRL_EN];
            end else if (avs_address == sbg_pkg::OFS_DIV_LO) begin
                next_div_lo = avs_writedata[7:0];
                sw_div_wr   = 1'b1;
            end else if (avs_address == sbg_pkg::OFS_DIV_HI) begin
                next_div_hi = avs_writedata[7:0];
                sw_div_wr   = 1'b1;
            end
        end
    end

    // a mode write also restarts, so no period mixes two widths
    assign clear = sw_div_wr || autobaud_load
                   || (wr_acc && (avs_address == sbg_pkg::OFS_CTRL));

    // period from next values so a restart loads the new divisor
    assign period = next_wide ? {next_div_hi, next_div_lo}
                              : {8'h00, next_div_lo};

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            state               <= sbg_pkg::SBG_BUS_IDLE;
            avs_readdata        <= 32'h0000_0000;
            wide_counter_select <= sbg_pkg::CTRL_BIT_RST; // 8-bit by default
            high_speed_select   <= sbg_pkg::CTRL_BIT_RST;
            sync_mode           <= sbg_pkg::CTRL_BIT_RST;
            port_enable         <= sbg_pkg::CTRL_BIT_RST;
            divisor_low_byte    <= sbg_pkg::DIV_RST;
            divisor_high_byte   <= sbg_pkg::DIV_RST;
        end else begin
            state               <= next_state;
            avs_readdata        <= next_readdata;
            wide_counter_select <= next_wide;
            high_speed_select   <= next_hs;
            sync_mode           <= next_sync;
            port_enable         <= next_en;
            divisor_low_byte    <= next_div_lo;
            divisor_high_byte   <= next_div_hi;
        end
    end

    // ************************************************************
    // period timer
    // ************************************************************
    sbg_timer u_timer (
        .clk_sys (clk_sys),
        .srst    (srst),
        .run     (next_en),
        .clear   (clear),
        .period  (period),
        .count   (count),
        .tick    (timer_tick)
    );

    // ************************************************************
    // bit period multiplier
    // ************************************************************
    always_comb begin
        if (sync_mode) begin
            mult = sbg_pkg::MULT_SYNC; // speed select not consulted
        end else if (!wide_counter_select && !high_speed_select) begin
            mult = sbg_pkg::MULT_ASYNC_8_LOW;
        end else if (!wide_counter_select) begin
            mult = sbg_pkg::MULT_ASYNC_8_HIGH;
        end else if (!high_speed_select) begin
            mult = sbg_pkg::MULT_ASYNC_16_LOW;
        end else begin
            mult = sbg_pkg::MULT_ASYNC_16_HIGH;
        end
    end

    always_comb begin
        next_pre      = pre;
        next_bit_tick = 1'b0;
        if (clear || !port_enable) begin
            next_pre = 6'h00;
        end else if (timer_tick) begin
            if ({1'b0, pre} == mult - 7'h01) begin
                next_pre      = 6'h00;
                next_bit_tick = 1'b1;
            end else begin
                next_pre = pre + 6'h01;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            pre      <= 6'h00;
            bit_tick <= 1'b0;
        end else begin
            pre      <= next_pre;
            bit_tick <= next_bit_tick;
        end
    end

    // ************************************************************
    // checks
    // ************************************************************
    logic [16:0] gap;
    logic [6:0]  nt;
    logic [16:0] next_gap;
    logic [6:0]  next_nt;

    // cycles since the last timer tick, timer ticks since the last bit tick
    always_comb begin
        next_gap = gap + 17'h00001;
        next_nt  = nt + {6'h00, timer_tick};
        if (clear || !port_enable) begin
            // a restart begins a fresh period, so old counts must not leak in
            next_gap = 17'h00000;
            next_nt  = 7'h00;
        end else begin
            if (timer_tick) begin
                next_gap = 17'h00001;
            end
            if (bit_tick) begin
                next_nt = {6'h00, timer_tick};
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            gap <= 17'h00000;
            nt  <= 7'h00;
        end else begin
            gap <= next_gap;
            nt  <= next_nt;
        end
    end

    a_reset_narrow: assert property (@(posedge clk_sys)
        $fell(srst) |-> !wide_counter_select)
        else $error("width not 8-bit after reset");
    a_wide_period: assert property (@(posedge clk_sys) disable iff (srst)
        timer_tick && wide_counter_select |->
            gap == {1'b0, divisor_high_byte, divisor_low_byte} + 17'h00001)
        else $error("16-bit period wrong");
    a_narrow_period: assert property (@(posedge clk_sys) disable iff (srst)
        timer_tick && !wide_counter_select |->
            gap == {9'h000, divisor_low_byte} + 17'h00001)
        else $error("8-bit period wrong");
    a_tick_only_enabled: assert property (@(posedge clk_sys) disable iff (srst)
        !port_enable ##1 !port_enable |-> !timer_tick && !bit_tick)
        else $error("tick while disabled");
    a_clear_on_write: assert property (@(posedge clk_sys) disable iff (srst)
        sw_div_wr |=> (count == (wide_counter_select ? {divisor_high_byte, divisor_low_byte}
                                 : {8'h00, divisor_low_byte})) && !timer_tick)
        else $error("divisor write did not restart timer");
    a_slow_async_mult: assert property (@(posedge clk_sys) disable iff (srst)
        bit_tick && !sync_mode && !wide_counter_select && !high_speed_select |-> nt == 7'h40)
        else $error("async 8-bit low speed not 64");
    a_async_mult_mix: assert property (@(posedge clk_sys) disable iff (srst)
        bit_tick && !sync_mode && (wide_counter_select != high_speed_select) |-> nt == 7'h10)
        else $error("async mixed multiplier not 16");
    a_async_mult_fast: assert property (@(posedge clk_sys) disable iff (srst)
        bit_tick && !sync_mode && wide_counter_select && high_speed_select |-> nt == 7'h04)
        else $error("async 16-bit high speed not 4");
    a_sync_mult: assert property (@(posedge clk_sys) disable iff (srst)
        bit_tick && sync_mode |-> nt == 7'h04)
        else $error("sync multiplier not 4");
    a_autobaud_load: assert property (@(posedge clk_sys) disable iff (srst)
        autobaud_load && !sw_div_wr |=>
            {divisor_high_byte, divisor_low_byte} == $past(autobaud_value) && count == period)
        else $error("auto-baud value not loaded");
    a_bus_answer: assert property (@(posedge clk_sys) disable iff (srst)
        (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("bus answer late");

    c_bit_slow: cover property (@(posedge clk_sys) disable iff (srst)
        bit_tick && !sync_mode && !wide_counter_select && !high_speed_select);
    c_bit_wide: cover property (@(posedge clk_sys) disable iff (srst)
        bit_tick && wide_counter_select && (divisor_high_byte != 8'h00));
    c_bit_sync: cover property (@(posedge clk_sys) disable iff (srst) bit_tick && sync_mode);
    c_autobaud: cover property (@(posedge clk_sys) disable iff (srst)
        autobaud_load && port_enable);

endmodule

// *** tb/sbg_port_model.sv ***
/*
 * behavioural far side of the bit-rate generator: receiver frame timing
 * and the auto-baud loader.
 * assumes clk_sys is shared with sbg_top and requests arrive from the bench.
 */
`timescale 1ns/100ps
module sbg_port_model (
    // clock and reset
    input  wire logic        clk_sys,
    input  wire logic        srst,
    // rate tick
    input  wire logic        bit_tick,
    // bench requests
    input  wire logic        rx_start,
    input  wire logic        ab_req,
    input  wire logic [15:0] ab_val,
    // to the generator
    output logic             receive_idle_flag,
    output logic             autobaud_load,
    output logic      [15:0] autobaud_value
);
    // ************************************************************
    // frame and loader
    // ************************************************************
    logic [3:0] bits_left;

    // idle only once every bit time of the frame has passed
    assign receive_idle_flag = (bits_left == 4'h0);

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            bits_left      <= 4'h0;
            autobaud_load  <= 1'b0;
            autobaud_value <= 16'h0000;
        end else begin
            if (rx_start) begin
                bits_left <= 4'hA;
            end else if (bit_tick && bits_left != 4'h0) begin
                bits_left <= bits_left - 4'h1;
            end
            autobaud_load  <= ab_req;
            // value means nothing without the pulse, so it churns meanwhile
            autobaud_value <= ab_req ? ab_val : ~autobaud_value;
        end
    end
endmodule

// *** tb/sbg_top_bench.sv ***
/*
 * self-checking bench for sbg_top: registers, tick spacing in every mode,
 * divisor restart, auto-baud load, receive-idle status, disable.
 * assumes sbg_port_model as far side and a 25 MHz clk_sys.
 */
`timescale 1ns/100ps
module sbg_top_bench;
    logic        clk_sys;
    logic        srst;
    logic [3:0]  avs_address;
    logic        avs_read;
    logic        avs_write;
    logic [31:0] avs_writedata;
    logic [3:0]  avs_byteenable;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        receive_idle_flag;
    logic        autobaud_load;
    logic [15:0] autobaud_value;
    logic        timer_tick;
    logic        bit_tick;
    logic        sync_mode;
    logic        wide_counter_select;
    logic        rx_start;
    logic        ab_req;
    logic [15:0] ab_val;
    logic [31:0] q;
    logic [7:0]  lo;
    integer      seed;
    int          fails;
    int          check_count;
    int          n;

    sbg_top dut (
        .clk_sys(clk_sys), .srst(srst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .receive_idle_flag(receive_idle_flag),
        .autobaud_load(autobaud_load), .autobaud_value(autobaud_value),
        .timer_tick(timer_tick), .bit_tick(bit_tick), .sync_mode(sync_mode),
        .wide_counter_select(wide_counter_select)
    );

    sbg_port_model port (
        .clk_sys(clk_sys), .srst(srst), .bit_tick(bit_tick), .rx_start(rx_start),
        .ab_req(ab_req), .ab_val(ab_val), .receive_idle_flag(receive_idle_flag),
        .autobaud_load(autobaud_load), .autobaud_value(autobaud_value)
    );

    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end

    // ************************************************************
    // helpers
    // ************************************************************
    task automatic conclude;
        if (fails == 0 && check_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // timer periods per bit; sync ignores the speed select
    function automatic int mult(input logic [2:0] m);
        if (m[2]) begin
            return sbg_pkg::MULT_SYNC;
        end
        case (m[1:0])
            2'b00: return 64;
            2'b11: return 4;
            default: return 16;
        endcase
    endfunction

    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
                       input logic [3:0] be);
        int k;
        @(posedge clk_sys);
        avs_address    <= a;
        avs_write      <= wr;
        avs_read       <= ~wr;
        avs_writedata  <= d;
        avs_byteenable <= be;
        k = 0;
        do begin
            @(posedge clk_sys);
            k++;
        end while (avs_waitrequest !== 1'b0 && k < 16);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
        if (avs_waitrequest !== 1'b0) begin
            fails++;
            conclude;
        end
    endtask

    // falling edges until the chosen tick is seen
    task automatic count_to(input logic which);
        n = 0;
        do begin
            @(negedge clk_sys);
            n++;
        end while ((which ? bit_tick : timer_tick) !== 1'b1 && n < 20000);
        if (n >= 20000) begin
            fails++;
            conclude;
        end
    endtask

    task automatic run_mode(input logic [2:0] m, input logic [7:0] dlo, input logic [7:0] dhi);
        int p;
        p = m[0] ? int'({dhi, dlo}) + 1 : int'(dlo) + 1;
        bus(1'b1, sbg_pkg::OFS_CTRL, {28'h0000000, 1'b1, m}, 4'hF);
        bus(1'b1, sbg_pkg::OFS_DIV_HI, {24'h000000, dhi}, 4'hF);
        bus(1'b1, sbg_pkg::OFS_DIV_LO, {24'h000000, dlo}, 4'hF);
        check("wide_out", wide_counter_select, m[0]);
        check("sync_out", sync_mode, m[2]);
        count_to(1'b0);
        check("first_tick", n, p + 1);
        count_to(1'b0);
        check("brg_period", n, p);
        if (p > 1) begin
            @(negedge clk_sys);
            check("tick_width", timer_tick, 1'b0);
        end
        count_to(1'b1);
        count_to(1'b1);
        check("bit_period", n, p * mult(m));
    endtask

    // ************************************************************
    // main sequence
    // ************************************************************
    initial begin
        seed           = 32'hF5968931;
        fails          = 0;
        check_count    = 0;
        srst           = 1'b1;
        avs_address    = 4'h0;
        avs_read       = 1'b0;
        avs_write      = 1'b0;
        avs_writedata  = 32'h00000000;
        avs_byteenable = 4'h0;
        rx_start       = 1'b0;
        ab_req         = 1'b0;
        ab_val         = 16'h0000;
        repeat (16) @(posedge clk_sys);
        srst <= 1'b0;
        bus(1'b0, sbg_pkg::OFS_CTRL, 32'h00000000, 4'hF);
        check("ctrl_reset", q, 32'h00000000);
        check("wide_reset", wide_counter_select, 1'b0);
        bus(1'b0, 4'h1, 32'h00000000, 4'hF);
        check("unmapped", q, 32'h00000000);
        bus(1'b1, sbg_pkg::OFS_DIV_LO, 32'h000000A5, 4'hE);
        bus(1'b0, sbg_pkg::OFS_DIV_LO, 32'h00000000, 4'hF);
        check("masked_write", q, 32'h00000000);
        // every width and speed choice software may make
        for (int m = 0; m < 8; m++) begin
            lo = 8'($random(seed) & 32'h1F);
            run_mode(3'(m), lo, 8'h01);
        end
        run_mode(3'b000, 8'h00, 8'h01);
        run_mode(3'b011, 8'hFF, 8'h00);
        // auto-baud load in mid-count
        @(posedge clk_sys);
        ab_val <= 16'h0123;
        ab_req <= 1'b1;
        @(posedge clk_sys);
        ab_req <= 1'b0;
        @(negedge clk_sys);
        check("ab_pulse", autobaud_load, 1'b1);
        count_to(1'b0);
        check("ab_first", n, 293);
        bus(1'b0, sbg_pkg::OFS_DIV_LO, 32'h00000000, 4'hF);
        check("ab_lo", q, 32'h00000023);
        bus(1'b0, sbg_pkg::OFS_DIV_HI, 32'h00000000, 4'hF);
        check("ab_hi", q, 32'h00000001);
        // receive frame seen through status
        run_mode(3'b100, 8'h00, 8'h00);
        @(posedge clk_sys);
        rx_start <= 1'b1;
        @(posedge clk_sys);
        rx_start <= 1'b0;
        bus(1'b0, sbg_pkg::OFS_STATUS, 32'h00000000, 4'hF);
        check("status_busy", q[1:0], 2'b10);
        repeat (60) @(posedge clk_sys);
        bus(1'b0, sbg_pkg::OFS_STATUS, 32'h00000000, 4'hF);
        check("status_idle", q[1:0], 2'b11);
        // disabled: a tick already launched may still land, so skip two
        bus(1'b1, sbg_pkg::OFS_CTRL, 32'h00000001, 4'hF);
        repeat (2) @(negedge clk_sys);
        n = 0;
        repeat (300) begin
            @(negedge clk_sys);
            if (timer_tick !== 1'b0 || bit_tick !== 1'b0) begin
                n++;
            end
        end
        check("ticks_off", n, 0);
        conclude;
    end
endmodule
